// ---- logic/fld_core.sv ----
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
// What this block does
// R1 - each option enabled, assigned acquire/recover
// R2 - pull-in and phase snap never together
// R3 - precedence fsnap, psnap, pull-in, wide
// R4 - measured offset loaded into divider
// R5 - optional slope limit on snap step
// R6 - phase snap sets phase immediately
// R7 - pull-in bypasses detector and filter
// R8 - wide limits applied until lock
// R9 - acquire only: max-bandwidth burst first
// R10 - divider word feeds outputs and feedback
// R11 - divide by integer plus 43-bit fraction
// R12 - host keeps ratio within bounds
// R13 - signed ps: negative advances, positive delays
// R14 - step by raising/lowering frequency briefly
// R15 - fast, medium, slow step rates
// R16 - unlimited repeated steps
// R17 - host steps only in open loop
// R18 - finish a step before next
module fld_core
  import fld_pkg::*;
#(
  parameter int INT_W     = 8,   // integer part width
  parameter int PRE_MS_W  = 8,   // pre-acquisition ms field width
  parameter int PRE_CYC_MS = FLD_CYC_PER_MS // cycles per ms, shortenable
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   acquire_lock_state,  // loop in acquire
  input  wire logic                   recover_lock_state,  // loop in recover
  input  wire logic                   lock_declared,       // lock achieved
  input  wire logic                   meas_valid,          // measurement pulse
  input  wire logic signed [31:0]     meas_freq_offset,    // fraction units
  input  wire logic signed [31:0]     meas_phase_offset,   // ps
  output logic      [INT_W-1:0]       div_int_q,           // to outputs and feedback
  output logic      [FLD_FRAC_W-1:0]  div_frac_q,
  output logic                        phase_snap_q,        // load phase now
  output logic signed [31:0]          phase_snap_val_q,
  output logic                        loop_bypass_q,       // pfd/lpf isolated
  output logic                        wide_active_q,       // relaxed limits on
  output logic                        bw_max_q,            // pre-acq burst
  output logic      [31:0]            acq_bw_q,
  output logic      [31:0]            acq_psl_q,
  output logic      [31:0]            wide_setup_q
);

  // ****************************************************************
  // checks
  // ****************************************************************
  initial begin
    if (INT_W < 5 || INT_W > 32) $error("INT_W out of range");
    if (PRE_CYC_MS < 1) $error("PRE_CYC_MS must be positive");
  end

  typedef enum logic [4:0] {
    FLD_IDLE = 5'h01, // waiting for a lock state
    FLD_PRE  = 5'h02, // bandwidth burst
    FLD_WIDE = 5'h04, // relaxed limits
    FLD_PULL = 5'h08, // open loop pull-in
    FLD_DONE = 5'h10  // option spent, wait for lock state exit
  } fld_state_e;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0]           opt_sel_q;     // option select
  logic [31:0]           snap_fsl_q;    // snap slope limit
  logic [31:0]           maxofs_q;      // max frequency offset
  logic [INT_W-1:0]      base_int_q;    // programmed integer
  logic [FLD_FRAC_W-1:0] base_frac_q;   // programmed fraction
  logic signed [31:0]    fine_rem_q;    // ps still to step
  logic signed [31:0]    fine_pend_q;   // queued step
  logic                  pend_q;
  logic signed [31:0]    meas_ofs_q;    // last applied snap offset
  fld_state_e            state_q;
  logic [31:0]           pre_cnt_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire acc     = psel & penable;
  // write lands only at the edge where pready is sampled high
  wire wr      = acc & pwrite & pready;
  wire hit_opt = paddr == FLD_OPT_SEL_ADDR;
  wire hit_any = hit_opt || paddr == FLD_WIDE_ADDR || paddr == FLD_ACQ_PSL_ADDR
              || paddr == FLD_ACQ_BW_ADDR || paddr == FLD_SNAP_FSL_ADDR
              || paddr == FLD_MAXOFS_ADDR || paddr == FLD_DIV_INT_ADDR
              || paddr == FLD_FRAC_LO_ADDR || paddr == FLD_FRAC_HI_ADDR
              || paddr == FLD_FINE_ADDR || paddr == FLD_STATUS_ADDR
              || paddr == FLD_MEAS_ADDR;
  wire wr_fine = wr && paddr == FLD_FINE_ADDR;

  // ****************************************************************
  // option selection
  // ****************************************************************
  // R1 per-state option gating
  wire [3:0] en_bits  = opt_sel_q[FLD_EN_LSB +: 4];
  wire [3:0] rec_bits = opt_sel_q[FLD_ASSIGN_LSB +: 4];
  wire [3:0] live     = en_bits & ((rec_bits & {4{recover_lock_state}})
                      | (~rec_bits & {4{acquire_lock_state}}));
  wire       in_lock_state = acquire_lock_state | recover_lock_state;
  // R3 fixed precedence
  wire sel_fsnap = live[FLD_OPT_FSNAP];
  wire sel_psnap = live[FLD_OPT_PSNAP] & ~sel_fsnap;
  // R2 pull-in excluded by phase snap
  wire sel_pull  = live[FLD_OPT_PULL] & ~live[FLD_OPT_PSNAP] & ~sel_fsnap;
  wire sel_wide  = live[FLD_OPT_WIDE] & ~sel_fsnap & ~live[FLD_OPT_PSNAP] & ~live[FLD_OPT_PULL];
  wire [1:0] rate = opt_sel_q[FLD_RATE_LSB +: 2];

  // R5 clamp to slope limit and max offset
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic [31:0] lim);
    logic signed [31:0] l;
    l = $signed({1'b0, lim[30:0]});
    clamp = (v > l) ? l : ((v < -l) ? -l : v);
  endfunction : clamp

  wire signed [31:0] snap_ofs0 = clamp(meas_freq_offset, maxofs_q);
  wire signed [31:0] snap_ofs  = opt_sel_q[FLD_FSL_EN_BIT] ? clamp(snap_ofs0, snap_fsl_q) : snap_ofs0;

  // ****************************************************************
  // fine phase step
  // ****************************************************************
  // R15 rate tables
  wire [15:0] dev = (rate == FLD_RATE_FAST) ? FLD_DEV_FAST : (rate == FLD_RATE_MED) ? FLD_DEV_MED : FLD_DEV_SLOW;
  wire [15:0] pps = (rate == FLD_RATE_FAST) ? FLD_PS_FAST : (rate == FLD_RATE_MED) ? FLD_PS_MED : FLD_PS_SLOW;
  wire signed [31:0] pps_s = $signed({16'h0000, pps});
  wire step_busy = fine_rem_q != 32'sh0;
  // R14 bounded deviation: last cycle consumes the remainder
  wire signed [31:0] take = (fine_rem_q > pps_s) ? pps_s : ((fine_rem_q < -pps_s) ? -pps_s : fine_rem_q);
  // R13 positive delays -> lower freq -> larger divide ratio
  wire [FLD_FRAC_W-1:0] dev_w = {{(FLD_FRAC_W-16){1'b0}}, dev};
  wire [FLD_FRAC_W-1:0] steer_frac = !step_busy ? base_frac_q
                                   : (fine_rem_q > 0) ? base_frac_q + dev_w : base_frac_q - dev_w;
  wire signed [FLD_FRAC_W:0] snap_w = {{(FLD_FRAC_W-31){meas_ofs_q[31]}}, meas_ofs_q};
  wire [FLD_FRAC_W-1:0] out_frac = steer_frac + snap_w[FLD_FRAC_W-1:0];

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_sel_q    <= 32'h0;
      wide_setup_q <= 32'h0;
      acq_psl_q    <= 32'h0;
      acq_bw_q     <= 32'h0;
      snap_fsl_q   <= 32'h0;
      maxofs_q     <= 32'h7FFFFFFF;
      base_int_q   <= '0;
      base_frac_q  <= '0;
    end else if (wr) begin
      if (hit_opt) opt_sel_q <= pwdata;
      else if (paddr == FLD_WIDE_ADDR) wide_setup_q <= pwdata;
      else if (paddr == FLD_ACQ_PSL_ADDR) acq_psl_q <= pwdata;
      else if (paddr == FLD_ACQ_BW_ADDR) acq_bw_q <= pwdata;
      else if (paddr == FLD_SNAP_FSL_ADDR) snap_fsl_q <= pwdata;
      else if (paddr == FLD_MAXOFS_ADDR) maxofs_q <= pwdata;
      // R11 integer and fraction parts
      else if (paddr == FLD_DIV_INT_ADDR) base_int_q <= pwdata[INT_W-1:0];
      else if (paddr == FLD_FRAC_LO_ADDR) base_frac_q[31:0] <= pwdata;
      else if (paddr == FLD_FRAC_HI_ADDR) base_frac_q[FLD_FRAC_W-1:32] <= pwdata[FLD_FRAC_HI_W-1:0];
    end
  end

  // ****************************************************************
  // fine step sequencing
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_rem_q  <= 32'sh0;
      fine_pend_q <= 32'sh0;
      pend_q      <= 1'b0;
    end else begin
      // R16 no limit on count of steps
      if (step_busy) fine_rem_q <= fine_rem_q - take;
      else if (pend_q) fine_rem_q <= fine_pend_q;
      // R18 queue while a step runs
      if (wr_fine) begin
        fine_pend_q <= $signed(pwdata);
        pend_q      <= 1'b1;
      end else if (!step_busy && pend_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // fast-lock sequencer
  // ****************************************************************
  wire [31:0] pre_ms  = {{(32-PRE_MS_W){1'b0}}, wide_setup_q[PRE_MS_W-1:0]};
  wire [31:0] pre_len = pre_ms * PRE_CYC_MS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= FLD_IDLE;
      pre_cnt_q        <= 32'h0;
      meas_ofs_q       <= 32'sh0;
      phase_snap_q     <= 1'b0;
      phase_snap_val_q <= 32'sh0;
    end else begin
      phase_snap_q <= 1'b0;
      case (state_q)
        FLD_IDLE: begin
          if (in_lock_state && meas_valid) begin
            // R4 load frequency offset
            if (sel_fsnap) begin
              meas_ofs_q <= snap_ofs;
              state_q    <= FLD_DONE;
            // R6 immediate phase set
            end else if (sel_psnap) begin
              phase_snap_q     <= 1'b1;
              phase_snap_val_q <= meas_phase_offset;
              state_q          <= FLD_DONE;
            end else if (sel_pull) begin
              phase_snap_val_q <= meas_phase_offset;
              state_q          <= FLD_PULL;
            // R9 burst only in acquire
            end else if (sel_wide && acquire_lock_state && opt_sel_q[FLD_PRE_EN_BIT] && pre_len != 0) begin
              pre_cnt_q <= pre_len;
              state_q   <= FLD_PRE;
            end else if (sel_wide) begin
              state_q <= FLD_WIDE;
            end
          end
        end
        FLD_PRE: begin
          pre_cnt_q <= pre_cnt_q - 32'h1;
          if (!in_lock_state) state_q <= FLD_IDLE;
          else if (pre_cnt_q == 32'h1) state_q <= FLD_WIDE;
        end
        // R8 relaxed until lock
        FLD_WIDE: begin
          if (lock_declared || !in_lock_state) state_q <= FLD_IDLE;
        end
        // R7 bypass until loop locks
        FLD_PULL: begin
          if (lock_declared || !in_lock_state) state_q <= FLD_IDLE;
        end
        FLD_DONE: begin
          if (!in_lock_state) state_q <= FLD_IDLE;
        end
        default: state_q <= FLD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_int_q     <= '0;
      div_frac_q    <= '0;
      loop_bypass_q <= 1'b0;
      wide_active_q <= 1'b0;
      bw_max_q      <= 1'b0;
    end else begin
      // R10 one divider word for both paths
      div_int_q     <= base_int_q;
      div_frac_q    <= out_frac;
      loop_bypass_q <= state_q == FLD_PULL;
      // R9 slope limit stays during burst
      wide_active_q <= state_q == FLD_WIDE || state_q == FLD_PRE;
      bw_max_q      <= state_q == FLD_PRE;
    end
  end

  // ****************************************************************
  // apb read
  // ****************************************************************
  wire [31:0] status = {24'h0, pend_q, step_busy, 1'b0, state_q};
  wire [31:0] rmux = hit_opt ? opt_sel_q
                   : paddr == FLD_WIDE_ADDR ? wide_setup_q
                   : paddr == FLD_ACQ_PSL_ADDR ? acq_psl_q
                   : paddr == FLD_ACQ_BW_ADDR ? acq_bw_q
                   : paddr == FLD_SNAP_FSL_ADDR ? snap_fsl_q
                   : paddr == FLD_MAXOFS_ADDR ? maxofs_q
                   : paddr == FLD_DIV_INT_ADDR ? {{(32-INT_W){1'b0}}, base_int_q}
                   : paddr == FLD_FRAC_LO_ADDR ? base_frac_q[31:0]
                   : paddr == FLD_FRAC_HI_ADDR ? {21'h0, base_frac_q[FLD_FRAC_W-1:32]}
                   : paddr == FLD_FINE_ADDR ? fine_rem_q
                   : paddr == FLD_STATUS_ADDR ? status
                   : paddr == FLD_MEAS_ADDR ? meas_ofs_q : 32'h0;

  // one wait state: pready rises in second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pwrite) ? rmux : 32'h0;
      pslverr <= acc & ~pready & ~hit_any;
    end
  end

endmodule : fld_core

// ---- logic/fld_pkg.sv ----
// ****************************************************************
// fast-lock / divider constants
// ****************************************************************
package fld_pkg;

  // register byte offsets
  localparam logic [7:0] FLD_OPT_SEL_ADDR  = 8'h00; // fast_lock_option_select
  localparam logic [7:0] FLD_WIDE_ADDR     = 8'h04; // wide_acquisition_setup
  localparam logic [7:0] FLD_ACQ_PSL_ADDR  = 8'h08; // acquisition_slope_limit
  localparam logic [7:0] FLD_ACQ_BW_ADDR   = 8'h0C; // acquisition_bandwidth
  localparam logic [7:0] FLD_SNAP_FSL_ADDR = 8'h10; // snap_slope_limit
  localparam logic [7:0] FLD_MAXOFS_ADDR   = 8'h14; // max_frequency_offset
  localparam logic [7:0] FLD_DIV_INT_ADDR  = 8'h18; // divider integer part
  localparam logic [7:0] FLD_FRAC_LO_ADDR  = 8'h1C; // fraction bits 31:0
  localparam logic [7:0] FLD_FRAC_HI_ADDR  = 8'h20; // fraction bits 42:32
  localparam logic [7:0] FLD_FINE_ADDR     = 8'h24; // fine adjust, signed ps
  localparam logic [7:0] FLD_STATUS_ADDR   = 8'h28; // status, read only
  localparam logic [7:0] FLD_MEAS_ADDR     = 8'h2C; // applied snap freq offset, after clamping

  // option_select fields: enable bits 3:0, recover-state assign bits 7:4
  localparam int FLD_EN_LSB    = 0;
  localparam int FLD_ASSIGN_LSB = 4;
  localparam int FLD_PRE_EN_BIT = 8;  // pre-acquisition burst enable
  localparam int FLD_RATE_LSB   = 9;  // two-bit rate select
  localparam int FLD_FSL_EN_BIT = 11; // slope-limit enable for snap

  // option index order is precedence order
  localparam int FLD_OPT_FSNAP = 0;
  localparam int FLD_OPT_PSNAP = 1;
  localparam int FLD_OPT_PULL  = 2;
  localparam int FLD_OPT_WIDE  = 3;

  localparam int FLD_FRAC_W = 43;
  localparam int FLD_FRAC_HI_W = 11;

  // phase step rates
  localparam logic [1:0] FLD_RATE_SLOW = 2'h0;
  localparam logic [1:0] FLD_RATE_MED  = 2'h1;
  localparam logic [1:0] FLD_RATE_FAST = 2'h2;

  // fraction deviation and ps per cycle consumed, per rate
  localparam logic [15:0] FLD_DEV_SLOW = 16'h0010;
  localparam logic [15:0] FLD_DEV_MED  = 16'h0100;
  localparam logic [15:0] FLD_DEV_FAST = 16'h1000;
  localparam logic [15:0] FLD_PS_SLOW  = 16'h0001;
  localparam logic [15:0] FLD_PS_MED   = 16'h0010;
  localparam logic [15:0] FLD_PS_FAST  = 16'h0100;

  // pre-acquisition time unit
  localparam int FLD_CLK_HZ = 50_000_000;
  localparam int FLD_MS_US  = 1000;
  localparam int FLD_CYC_PER_MS = FLD_CLK_HZ / 1000;

endpackage : fld_pkg

// ---- test/fld_core_asserts.sv ----
`timescale 1ns/1ps
// ****************************************
// port checks for the fast-lock divider
// ****************************************
module fld_core_asserts
  import fld_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        acquire_lock_state,
  input wire logic        lock_declared,
  input wire logic        phase_snap_q,
  input wire logic        loop_bypass_q,
  input wire logic        wide_active_q,
  input wire logic        bw_max_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle then first access cycle
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // one-cycle answer
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_wait: assert property (s_setup_access |=> s_answer)
    else $error("apb answer not after one wait state");
  a_apb_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_apb_unmapped: assert property (pready && paddr > FLD_MEAS_ADDR |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_apb_mapped: assert property (pready && paddr <= FLD_MEAS_ADDR && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_snap_pulse: assert property ($rose(phase_snap_q) |=> !phase_snap_q)
    else $error("phase snap not a single pulse");
  a_snap_no_pull: assert property (phase_snap_q |-> !loop_bypass_q)
    else $error("phase snap and pull-in together");
  a_burst_acq_only: assert property (bw_max_q |-> wide_active_q && $past(acquire_lock_state))
    else $error("burst outside acquire or without wide");
  a_pull_release: assert property (loop_bypass_q && lock_declared |-> ##2 !loop_bypass_q)
    else $error("bypass held after lock");
  a_wide_release: assert property (wide_active_q && !bw_max_q && lock_declared |-> ##2 !wide_active_q)
    else $error("wide limits held after lock");
endmodule : fld_core_asserts

bind fld_core fld_core_asserts u_fld_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .acquire_lock_state(acquire_lock_state), .lock_declared(lock_declared), .phase_snap_q(phase_snap_q),
  .loop_bypass_q(loop_bypass_q), .wide_active_q(wide_active_q), .bw_max_q(bw_max_q));

// ---- test/tb_dpll_fast_lock_fractional_divider.sv ----
`timescale 1ns/1ps
module tb_dpll_fast_lock_fractional_divider
  import fld_pkg::*;
;
  localparam logic [42:0] BASE = {11'h100, 32'h0000_1000};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, acq_bw_q, acq_psl_q, wide_setup_q, rdv;
  logic        pready, pslverr, phase_snap_q, loop_bypass_q, wide_active_q, bw_max_q, erv;
  logic        acq = 1'b0, rec = 1'b0, lck = 1'b0, mv = 1'b0;
  logic signed [31:0] mfo = 32'h0, mpo = 32'h0, phase_snap_val_q;
  logic [7:0]  div_int_q;
  logic [42:0] div_frac_q, dev = '0;
  logic [15:0] devs [3] = '{FLD_DEV_SLOW, FLD_DEV_MED, FLD_DEV_FAST};
  int          cycs [3] = '{256, 16, 1};
  int          n_errors = 0, tests_run = 0, cyc = 0;
  int          cnt [6];   // snap, bypass, burst, wide, step up, step down

  fld_core #(.PRE_CYC_MS(5)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acquire_lock_state(acq), .recover_lock_state(rec), .lock_declared(lck), .meas_valid(mv),
    .meas_freq_offset(mfo), .meas_phase_offset(mpo), .div_int_q(div_int_q), .div_frac_q(div_frac_q),
    .phase_snap_q(phase_snap_q), .phase_snap_val_q(phase_snap_val_q), .loop_bypass_q(loop_bypass_q),
    .wide_active_q(wide_active_q), .bw_max_q(bw_max_q), .acq_bw_q(acq_bw_q), .acq_psl_q(acq_psl_q),
    .wide_setup_q(wide_setup_q));

  always #10 pclk = ~pclk;

  // per-cycle output tallies and hang guard
  always @(posedge pclk) begin
    cnt[0] += (phase_snap_q === 1'b1);
    cnt[1] += (loop_bypass_q === 1'b1);
    cnt[2] += (bw_max_q === 1'b1);
    cnt[3] += (wide_active_q === 1'b1);
    cnt[4] += (div_frac_q === BASE + dev);
    cnt[5] += (div_frac_q === BASE - dev);
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("mismatches=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rdv, e); endtask : rd
  task automatic clr(); @(negedge pclk); foreach (cnt[i]) cnt[i] = 0; endtask : clr
  task automatic wt(input int n); repeat (n) @(posedge pclk); @(negedge pclk); endtask : wt

  // loop state levels
  task automatic arm(input logic a, input logic r, input logic l);
    @(posedge pclk);
    acq <= a; rec <= r; lck <= l;
  endtask : arm

  // one measurement pulse
  task automatic trig(input logic [31:0] fo, input logic [31:0] po);
    @(posedge pclk);
    mv <= 1'b1; mfo <= fo; mpo <= po;
    @(posedge pclk);
    mv <= 1'b0;
  endtask : trig

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(FLD_MAXOFS_ADDR, 32'h7FFF_FFFF);
    rd(FLD_OPT_SEL_ADDR, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(erv, 1'b1);
    wr(FLD_DIV_INT_ADDR, 32'h14); // ratio in range
    wr(FLD_FRAC_LO_ADDR, 32'h1000);
    wr(FLD_FRAC_HI_ADDR, 32'h100);
    wr(FLD_WIDE_ADDR, 32'h2);
    wr(FLD_SNAP_FSL_ADDR, 32'h40);
    wr(FLD_ACQ_BW_ADDR, 32'h33);
    wr(FLD_ACQ_PSL_ADDR, 32'h44);
    wt(1);
    chk({div_int_q, div_frac_q}, {8'h14, BASE});
    chk({acq_bw_q, acq_psl_q}, {32'h33, 32'h44});
    // fine steps per rate, loop open (no lock state)
    for (int r = 0; r < 3; r++) begin
      wr(FLD_OPT_SEL_ADDR, 32'(r) << FLD_RATE_LSB);
      dev = 43'(devs[r]);
      clr();
      wr(FLD_FINE_ADDR, 32'h100); // open loop
      wt(300);
      chk(cnt[4], cycs[r]);
      chk(div_frac_q, BASE);
    end
    wr(FLD_OPT_SEL_ADDR, 32'h200); // medium rate
    dev = 43'(devs[1]);
    clr();
    wr(FLD_FINE_ADDR, 32'hFFFF_FF00);
    wt(60);
    chk({cnt[4], cnt[5]}, {32'd0, 32'd16});
    clr();
    wr(FLD_FINE_ADDR, 32'h100);
    wr(FLD_FINE_ADDR, 32'h100);
    wt(80);
    chk(cnt[4], 32);
    rd(FLD_FINE_ADDR, 32'h0);
    dev = '0;
    // all options on: frequency snap wins
    wr(FLD_OPT_SEL_ADDR, 32'hF);
    clr();
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h100, 32'h55);
    wt(5);
    chk({cnt[0], cnt[1]}, 0);
    chk(cnt[3], 0);
    chk(div_frac_q, BASE + 43'h100);
    rd(FLD_MEAS_ADDR, 32'h100);
    arm(1'b0, 1'b0, 1'b0);
    wr(FLD_OPT_SEL_ADDR, 32'h801);
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h100, 32'h0);
    wt(5);
    chk(div_frac_q, BASE + 43'h40);
    arm(1'b0, 1'b0, 1'b0);
    // phase snap with pull-in also enabled
    wr(FLD_OPT_SEL_ADDR, 32'h6);
    clr();
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h0, 32'h1234);
    wt(5);
    chk({cnt[0], cnt[1]}, {32'd1, 32'd0});
    chk(phase_snap_val_q, 32'h1234);
    arm(1'b0, 1'b0, 1'b0);
    // open-loop pull-in until lock
    wr(FLD_OPT_SEL_ADDR, 32'h4);
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h0, 32'h10);
    wt(5);
    chk(loop_bypass_q, 1'b1);
    arm(1'b1, 1'b0, 1'b1);
    wt(3);
    chk(loop_bypass_q, 1'b0);
    arm(1'b0, 1'b0, 1'b0);
    // wide with burst in acquire: 2 ms of 5 cycles
    wr(FLD_OPT_SEL_ADDR, 32'h108);
    clr();
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h0, 32'h0);
    wt(30);
    chk({cnt[2], 31'h0, wide_active_q}, {32'd10, 32'd1});
    arm(1'b1, 1'b0, 1'b1);
    wt(3);
    chk(wide_active_q, 1'b0);
    arm(1'b0, 1'b0, 1'b0);
    // wide assigned to recover: acquire ignored, no burst
    wr(FLD_OPT_SEL_ADDR, 32'h188);
    clr();
    arm(1'b1, 1'b0, 1'b0);
    trig(32'h0, 32'h0);
    wt(20);
    chk(cnt[3], 0);
    arm(1'b0, 1'b0, 1'b0);
    arm(1'b0, 1'b1, 1'b0);
    trig(32'h0, 32'h0);
    wt(20);
    chk({cnt[2], 31'h0, wide_active_q}, {32'd0, 32'd1});
    arm(1'b0, 1'b0, 1'b0);
    wt(2);
    close_out();
  end
endmodule : tb_dpll_fast_lock_fractional_divider
